// [include/frp_pkg.sv]
package frp_pkg;

  // Command opcodes and fields
  localparam logic [5:0] FRP_BIAS_OPCODE = 6'h01;
  localparam int FRP_BIAS_OP_LSB = 2;
  localparam logic [2:0] FRP_LCD_OPCODE = 3'h1;
  localparam int FRP_LCD_OP_LSB = 5;
  localparam logic [3:0] FRP_PWM_OPCODE = 4'h4;
  localparam int FRP_PWM_OP_LSB = 4;
  localparam logic [4:0] FRP_LCD_SEL_MAX = 5'h16;

  // Reset values
  localparam logic [1:0] FRP_BIAS_RESET = 2'h0;
  localparam logic [4:0] FRP_LCD_SEL_RESET = 5'h0E;
  localparam logic [3:0] FRP_PWM_SEL_RESET = 4'h0;

  // Fixed division ratios
  localparam logic [7:0] FRP_LCD_FRAME_DIV = 8'h30;
  localparam logic [7:0] FRP_PWM_FRAME_DIV = 8'h80;
  localparam logic [7:0] FRP_DIV_ONE = 8'h01;

  // Bias level decoded from the bias select field
  typedef enum logic [1:0] {
    FRP_BIAS_QUARTER = 2'b00,
    FRP_BIAS_THIRD = 2'b01,
    FRP_BIAS_HALF = 2'b10
  } frp_bias_t;

  // Divide factor q for each LCD divider code
  function automatic logic [7:0] frp_lcd_q(input logic [4:0] sel);
    logic [7:0] q;
    q = 8'h10;
    unique case (sel)
      5'h00: q = 8'h50;
      5'h01: q = 8'h44;
      5'h02: q = 8'h3C;
      5'h03: q = 8'h35;
      5'h04: q = 8'h30;
      5'h05: q = 8'h2C;
      5'h06: q = 8'h28;
      5'h07: q = 8'h25;
      5'h08: q = 8'h22;
      5'h09: q = 8'h20;
      5'h0A: q = 8'h1E;
      5'h0B: q = 8'h1C;
      5'h0C: q = 8'h1B;
      5'h0D: q = 8'h19;
      5'h0E: q = 8'h18;
      5'h0F: q = 8'h17;
      5'h10: q = 8'h16;
      5'h11: q = 8'h15;
      5'h12: q = 8'h14;
      5'h13: q = 8'h13;
      5'h14: q = 8'h12;
      5'h15: q = 8'h11;
      default: q = 8'h10;
    endcase
    return q;
  endfunction

  // Divide factor p for each PWM divider code
  function automatic logic [7:0] frp_pwm_p(input logic [3:0] sel);
    logic [7:0] p;
    p = 8'h06;
    unique case (sel)
      4'h0: p = 8'h1E;
      4'h1: p = 8'h1A;
      4'h2: p = 8'h16;
      4'h3: p = 8'h14;
      4'h4: p = 8'h12;
      4'h5: p = 8'h10;
      4'h6: p = 8'h0F;
      4'h7: p = 8'h0E;
      4'h8: p = 8'h0D;
      4'h9: p = 8'h0C;
      4'hA: p = 8'h0B;
      4'hB: p = 8'h0A;
      4'hC: p = 8'h09;
      4'hD: p = 8'h08;
      4'hE: p = 8'h07;
      4'hF: p = 8'h06;
    endcase
    return p;
  endfunction

  // Bias level for a bias select code
  function automatic frp_bias_t frp_bias_decode(input logic [1:0] sel);
    frp_bias_t b;
    b = FRP_BIAS_QUARTER;
    unique case (sel)
      2'b00: b = FRP_BIAS_QUARTER;
      2'b01: b = FRP_BIAS_QUARTER;
      2'b11: b = FRP_BIAS_THIRD;
      2'b10: b = FRP_BIAS_HALF;
    endcase
    return b;
  endfunction

endpackage

// [verilog/frp_divider.sv]
`timescale 1ns/100ps
module frp_divider
  import frp_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Input ticks and ratio
  input wire logic tick_i,
  input wire logic [7:0] divisor_i,
  // Count and wrap pulse
  output logic [7:0] count_o,
  output logic wrap_o
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_inc;
  logic wrap_q;

  assign cnt_inc = cnt_q + FRP_DIV_ONE;

  // Counts input ticks, wraps after divisor ticks
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_q <= 8'h00;
    end else if (tick_i) begin
      if (cnt_inc >= divisor_i) begin
        cnt_q <= 8'h00;
      end else begin
        cnt_q <= cnt_inc;
      end
    end
  end

  // One-cycle pulse on each wrap
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wrap_q <= 1'b0;
    end else begin
      wrap_q <= tick_i && (cnt_inc >= divisor_i);
    end
  end

  assign count_o = cnt_q;
  assign wrap_o = wrap_q;

endmodule

// [verilog/frp_frame_rate_prescaler.sv]
`timescale 1ns/100ps
module frp_frame_rate_prescaler
  import frp_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Command bytes from the serial interface
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_byte_i,
  // Oscillator control bits
  input wire logic power_down_i,
  input wire logic external_osc_i,
  input wire logic external_clock_rate_select_i,
  input wire logic clock_out_enable_i,
  input wire logic pwm_enable_i,
  // Internal oscillator
  input wire logic int_osc_tick_i,
  output logic int_osc_run_o,
  // Oscillator clock pin
  input wire logic oscillator_clock_pin_i,
  output logic oscillator_clock_pin_o,
  output logic oscillator_clock_pin_oe_o,
  // Configuration state
  output logic [1:0] bias_select_o,
  output frp_bias_t bias_level_o,
  output logic [4:0] lcd_frame_divider_select_o,
  output logic [3:0] pwm_frame_divider_select_o,
  output logic [7:0] lcd_divide_factor_o,
  output logic [7:0] pwm_divide_factor_o,
  // Derived timing pulses
  output logic intermediate_tick_o,
  output logic lcd_frame_tick_o,
  output logic pwm_clock_tick_o,
  output logic pwm_frame_tick_o
);

  logic [1:0] bias_sel_q;
  logic [4:0] lcd_sel_q;
  logic [3:0] pwm_sel_q;
  logic [7:0] lcd_q_q;
  logic [7:0] pwm_p_q;
  logic pin_meta_q;
  logic pin_sync_q;
  logic pin_prev_q;
  logic pin_rise;
  logic osc_run;
  logic osc_tick;
  logic slow_ext;
  logic work_tick;
  logic pwm_src_tick;
  logic [7:0] prescale_div;
  logic [7:0] prescale_cnt;
  logic inter_wrap;
  logic lcd_wrap;
  logic pwm_pre_wrap;
  logic pwm_wrap;
  logic clk_out_q;
  logic is_bias_cmd;
  logic is_lcd_cmd;
  logic is_pwm_cmd;

  // Command decode
  assign is_bias_cmd = cmd_valid_i &&
    (cmd_byte_i[7:FRP_BIAS_OP_LSB] == FRP_BIAS_OPCODE);
  assign is_lcd_cmd = cmd_valid_i &&
    (cmd_byte_i[7:FRP_LCD_OP_LSB] == FRP_LCD_OPCODE);
  assign is_pwm_cmd = cmd_valid_i &&
    (cmd_byte_i[7:FRP_PWM_OP_LSB] == FRP_PWM_OPCODE);

  // Bias select field
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bias_sel_q <= FRP_BIAS_RESET;
    end else if (is_bias_cmd) begin
      bias_sel_q <= cmd_byte_i[1:0];
    end
  end

  // LCD divider select and its factor
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lcd_sel_q <= FRP_LCD_SEL_RESET;
      lcd_q_q <= frp_lcd_q(FRP_LCD_SEL_RESET);
    end else if (is_lcd_cmd && (cmd_byte_i[4:0] <= FRP_LCD_SEL_MAX)) begin
      lcd_sel_q <= cmd_byte_i[4:0];
      lcd_q_q <= frp_lcd_q(cmd_byte_i[4:0]);
    end
  end

  // PWM divider select and its factor
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pwm_sel_q <= FRP_PWM_SEL_RESET;
      pwm_p_q <= frp_pwm_p(FRP_PWM_SEL_RESET);
    end else if (is_pwm_cmd) begin
      pwm_sel_q <= cmd_byte_i[3:0];
      pwm_p_q <= frp_pwm_p(cmd_byte_i[3:0]);
    end
  end

  // Clock pin synchroniser and rising edge
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_meta_q <= oscillator_clock_pin_i;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  assign pin_rise = pin_sync_q && !pin_prev_q;

  // External clock of 9.6 kHz selected
  assign slow_ext = external_osc_i && !external_clock_rate_select_i;

  // Internal oscillator on when used, or when PWM needs it
  assign osc_run = !power_down_i && (!external_osc_i || (pwm_enable_i && slow_ext));
  assign osc_tick = osc_run && int_osc_tick_i;

  // Working clock from the pin or the internal oscillator
  assign work_tick = !power_down_i && (external_osc_i ? pin_rise : osc_tick);

  // Prescaler is q at 230 kHz, bypassed at 9.6 kHz
  assign prescale_div = slow_ext ? FRP_DIV_ONE : lcd_q_q;

  // PWM runs from 230 kHz, the internal oscillator covering 9.6 kHz
  assign pwm_src_tick = pwm_enable_i && (slow_ext ? osc_tick : work_tick);

  frp_divider u_prescale (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .tick_i(work_tick),
    .divisor_i(prescale_div),
    .count_o(prescale_cnt),
    .wrap_o(inter_wrap)
  );

  // Frame divides the intermediate clock by 48
  frp_divider u_lcd_frame (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .tick_i(inter_wrap),
    .divisor_i(FRP_LCD_FRAME_DIV),
    .count_o(),
    .wrap_o(lcd_wrap)
  );

  frp_divider u_pwm_pre (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .tick_i(pwm_src_tick),
    .divisor_i(pwm_p_q),
    .count_o(),
    .wrap_o(pwm_pre_wrap)
  );

  // PWM frame divides the p-scaled clock by 128
  frp_divider u_pwm_frame (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .tick_i(pwm_pre_wrap),
    .divisor_i(FRP_PWM_FRAME_DIV),
    .count_o(),
    .wrap_o(pwm_wrap)
  );

  // Intermediate clock level, high for the first half of q
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      clk_out_q <= 1'b0;
    end else if (power_down_i) begin
      clk_out_q <= 1'b1;
    end else begin
      clk_out_q <= (prescale_cnt < {1'b0, lcd_q_q[7:1]});
    end
  end

  // Pin drives only with output enabled and either power down or the internal oscillator in use
  assign oscillator_clock_pin_oe_o = clock_out_enable_i &&
    (power_down_i || !external_osc_i);
  assign oscillator_clock_pin_o = clk_out_q;

  assign int_osc_run_o = osc_run;
  assign bias_select_o = bias_sel_q;
  assign bias_level_o = frp_bias_decode(bias_sel_q);
  assign lcd_frame_divider_select_o = lcd_sel_q;
  assign pwm_frame_divider_select_o = pwm_sel_q;
  assign lcd_divide_factor_o = lcd_q_q;
  assign pwm_divide_factor_o = pwm_p_q;
  assign intermediate_tick_o = inter_wrap;
  assign lcd_frame_tick_o = lcd_wrap;
  assign pwm_clock_tick_o = pwm_pre_wrap;
  assign pwm_frame_tick_o = pwm_wrap;

endmodule

// [verif/frp_properties.sv]
`timescale 1ns/100ps
module frp_properties
  import frp_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Commands and mode bits
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_byte_i,
  input wire logic power_down_i,
  input wire logic external_osc_i,
  input wire logic external_clock_rate_select_i,
  input wire logic clock_out_enable_i,
  input wire logic pwm_enable_i,
  // Design outputs
  input wire logic int_osc_run_o,
  input wire logic oscillator_clock_pin_o,
  input wire logic oscillator_clock_pin_oe_o,
  input wire logic [1:0] bias_select_o,
  input wire frp_bias_t bias_level_o,
  input wire logic [4:0] lcd_frame_divider_select_o,
  input wire logic [3:0] pwm_frame_divider_select_o,
  input wire logic [7:0] lcd_divide_factor_o,
  input wire logic intermediate_tick_o,
  input wire logic lcd_frame_tick_o,
  input wire logic pwm_clock_tick_o,
  input wire logic pwm_frame_tick_o
);
  logic [7:0] icnt_q;
  logic [7:0] pcnt_q;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // Intermediate ticks since the last LCD frame
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) icnt_q <= 8'h00;
    else icnt_q <= (lcd_frame_tick_o ? 8'h00 : icnt_q) + {7'h00, intermediate_tick_o};
  end
  // PWM clock ticks since the last PWM frame
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) pcnt_q <= 8'h00;
    else pcnt_q <= (pwm_frame_tick_o ? 8'h00 : pcnt_q) + {7'h00, pwm_clock_tick_o};
  end
  chk_bias_take: assert property (cmd_valid_i && cmd_byte_i[7:2] == 6'h01
    |=> bias_select_o == $past(cmd_byte_i[1:0])) else $error("bias select not taken");
  chk_bias_level: assert property (bias_level_o == (bias_select_o == 2'h3 ?
    FRP_BIAS_THIRD : bias_select_o == 2'h2 ? FRP_BIAS_HALF : FRP_BIAS_QUARTER))
    else $error("bias level wrong");
  chk_lcd_take: assert property (cmd_valid_i && cmd_byte_i[7:5] == 3'h1
    && cmd_byte_i[4:0] <= 5'h16 |=> lcd_frame_divider_select_o == $past(cmd_byte_i[4:0]))
    else $error("lcd select not taken");
  chk_lcd_keep: assert property (cmd_valid_i && cmd_byte_i[7:5] == 3'h1
    && cmd_byte_i[4:0] > 5'h16 |=> $stable(lcd_frame_divider_select_o)
    && $stable(lcd_divide_factor_o)) else $error("unused lcd code changed state");
  chk_pwm_take: assert property (cmd_valid_i && cmd_byte_i[7:4] == 4'h4
    |=> pwm_frame_divider_select_o == $past(cmd_byte_i[3:0])) else $error("pwm select lost");
  chk_pin_enable: assert property (oscillator_clock_pin_oe_o == (clock_out_enable_i
    && (power_down_i || !external_osc_i))) else $error("pin enable wrong");
  chk_pin_idle: assert property ($past(power_down_i) && !$past(sys_rst_i)
    |-> oscillator_clock_pin_o) else $error("pin not high in power down");
  chk_osc_start: assert property (int_osc_run_o == (!power_down_i && (!external_osc_i
    || pwm_enable_i && !external_clock_rate_select_i))) else $error("oscillator run wrong");
  chk_lcd_frame: assert property (lcd_frame_tick_o |-> icnt_q == 8'h30)
    else $error("lcd frame not 48 ticks");
  chk_pwm_frame: assert property (pwm_frame_tick_o |-> pcnt_q == 8'h80)
    else $error("pwm frame not 128 ticks");
  cov_lcd_frame: cover property (lcd_frame_tick_o);
  cov_pwm_frame: cover property (pwm_frame_tick_o);
  cov_third_bias: cover property (bias_level_o == FRP_BIAS_THIRD);
  cov_pin_clock: cover property (oscillator_clock_pin_oe_o && $rose(oscillator_clock_pin_o));
endmodule
bind frp_frame_rate_prescaler frp_properties chk_u (.mclk_i, .sys_rst_i, .cmd_valid_i,
  .cmd_byte_i, .power_down_i, .external_osc_i, .external_clock_rate_select_i,
  .clock_out_enable_i, .pwm_enable_i, .int_osc_run_o, .oscillator_clock_pin_o,
  .oscillator_clock_pin_oe_o, .bias_select_o, .bias_level_o, .lcd_frame_divider_select_o,
  .pwm_frame_divider_select_o, .lcd_divide_factor_o, .intermediate_tick_o,
  .lcd_frame_tick_o, .pwm_clock_tick_o, .pwm_frame_tick_o);

// [verif/frp_host_model.sv]
`timescale 1ns/100ps
module frp_host_model (
  // Clock
  input wire logic mclk_i,
  // Command bytes
  output logic cmd_valid_o,
  output logic [7:0] cmd_byte_o,
  // External clock source, four cycles a period
  output logic ext_clk_o
);
  logic [1:0] div_q = 2'h0;
  initial cmd_valid_o = 1'b0;
  initial cmd_byte_o = 8'h00;
  always @(posedge mclk_i) div_q <= div_q + 2'h1;
  assign ext_clk_o = div_q[1];
  // One byte per call; the byte lines carry junk when idle
  task automatic send(input logic [7:0] b);
    @(posedge mclk_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_byte_o = b;
    @(posedge mclk_i);
    #1;
    cmd_valid_o = 1'b0;
    cmd_byte_o = ~b;
  endtask
endmodule

// [verif/testbench.sv]
`timescale 1ns/100ps
module testbench;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic pd, ext, rate, coe, pwm_en, osc_tick, run, pin_out, pin_oe, ext_clk, cmd_valid;
  logic lcd_tk, pwm_tk;
  logic [7:0] cmd_byte, lq, pp;
  logic [1:0] bsel, e_b;
  logic [4:0] lsel, e_l;
  logic [3:0] psel, e_p;
  frp_pkg::frp_bias_t blvl;
  wire logic pin = pin_oe ? pin_out : ext_clk;
  int fails = 0;
  int total_checks = 0;
  logic [7:0] qt [23] = '{8'h50, 8'h44, 8'h3C, 8'h35, 8'h30, 8'h2C, 8'h28, 8'h25, 8'h22,
    8'h20, 8'h1E, 8'h1C, 8'h1B, 8'h19, 8'h18, 8'h17, 8'h16, 8'h15, 8'h14, 8'h13, 8'h12,
    8'h11, 8'h10};
  logic [7:0] pt [16] = '{8'h1E, 8'h1A, 8'h16, 8'h14, 8'h12, 8'h10, 8'h0F, 8'h0E, 8'h0D,
    8'h0C, 8'h0B, 8'h0A, 8'h09, 8'h08, 8'h07, 8'h06};
  always #5 mclk_i = ~mclk_i;
  frp_host_model host_u (.mclk_i, .cmd_valid_o(cmd_valid), .cmd_byte_o(cmd_byte),
    .ext_clk_o(ext_clk));
  frp_frame_rate_prescaler dut_u (.mclk_i, .sys_rst_i, .cmd_valid_i(cmd_valid),
    .cmd_byte_i(cmd_byte), .power_down_i(pd), .external_osc_i(ext),
    .external_clock_rate_select_i(rate), .clock_out_enable_i(coe), .pwm_enable_i(pwm_en),
    .int_osc_tick_i(osc_tick), .int_osc_run_o(run), .oscillator_clock_pin_i(pin),
    .oscillator_clock_pin_o(pin_out), .oscillator_clock_pin_oe_o(pin_oe),
    .bias_select_o(bsel), .bias_level_o(blvl), .lcd_frame_divider_select_o(lsel),
    .pwm_frame_divider_select_o(psel), .lcd_divide_factor_o(lq), .pwm_divide_factor_o(pp),
    .intermediate_tick_o(), .lcd_frame_tick_o(lcd_tk), .pwm_clock_tick_o(),
    .pwm_frame_tick_o(pwm_tk));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [1:0] lvl_of(input logic [1:0] s);
    return s == 2'h3 ? 2'h1 : (s == 2'h2 ? 2'h2 : 2'h0);
  endfunction
  // Send a byte, predict the new settings and compare them all
  task automatic issue(input logic [7:0] b);
    host_u.send(b);
    if (b[7:2] == 6'h01) e_b = b[1:0];
    if (b[7:5] == 3'h1 && b[4:0] <= 5'h16) e_l = b[4:0];
    if (b[7:4] == 4'h4) e_p = b[3:0];
    check(16'(bsel), 16'(e_b));
    check(16'(blvl), 16'(lvl_of(e_b)));
    check(16'(lsel), 16'(e_l));
    check(16'(lq), 16'(qt[e_l]));
    check(16'(psel), 16'(e_p));
    check(16'(pp), 16'(pt[e_p]));
  endtask
  // Cycles between two frame pulses, or two pin rises for kind 2
  task automatic gap(input int w, output int n);
    logic prev;
    logic hit;
    prev = 1'b1;
    hit = 1'b0;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge mclk_i);
        #1;
        n++;
        if (n > 9000) begin
          fails++;
          stop_test();
        end
        if (w == 2) begin
          hit = pin_out === 1'b1 && prev === 1'b0;
        end else begin
          hit = (w == 1 ? pwm_tk : lcd_tk) === 1'b1;
        end
        prev = pin_out;
      end while (!hit);
    end
  endtask
  initial begin
    int n;
    void'($urandom(92));
    {pd, ext, rate, coe, pwm_en, osc_tick} = 6'h01;
    {e_b, e_l, e_p} = {2'h0, 5'h0E, 4'h0};
    repeat (16) @(posedge mclk_i);
    #1;
    sys_rst_i = 1'b0;
    issue(8'hFF);
    for (int i = 0; i < 32; i++) begin
      issue({6'h01, i[1:0]});
      issue({3'h1, i[4:0]});
      issue({4'h4, i[3:0]});
    end
    repeat (60) issue(8'($urandom));
    for (int i = 0; i < 32; i++) begin
      {pd, ext, pwm_en, rate, coe} = i[4:0];
      @(posedge mclk_i);
      #1;
      check(16'(run), 16'(!pd && (!ext || pwm_en && !rate)));
      check(16'(pin_oe), 16'(coe && (pd || !ext)));
      if (pd) check(16'(pin_out), 16'h1);
    end
    issue(8'h36);
    issue(8'h4C);
    {pd, ext, rate, coe, pwm_en} = 5'h03;
    gap(0, n);
    check(16'(n), 16'h0300);
    gap(1, n);
    check(16'(n), 16'h0480);
    gap(2, n);
    check(16'(n), 16'h0010);
    issue(8'h20);
    gap(2, n);
    check(16'(n), 16'h0050);
    issue(8'h36);
    {pd, ext, rate, coe, pwm_en} = 5'h09;
    gap(0, n);
    check(16'(n), 16'h00C0);
    gap(1, n);
    check(16'(n), 16'h0480);
    {pd, ext, rate, coe, pwm_en} = 5'h0D;
    gap(0, n);
    check(16'(n), 16'h0C00);
    gap(1, n);
    check(16'(n), 16'h1200);
    stop_test();
  end
endmodule
